// ===== rtl/sart_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "sart_map.svh"

module sart_timer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // pins from outside the clock domain
    input  wire logic       ext_clk_in,
    input  wire logic       lfo_clk_in,
    input  wire logic       suspend_in,
    // interrupt request
    output logic            irq_req
);

    // pick a byte's tick from its clock select and the shared field
    function automatic logic sel_tick(input logic sys_sel, input logic [1:0] xsel,
                                      input logic t12, input logic tx, input logic tl);
        logic t;
        t = 1'b0;
        if (sys_sel) begin
            t = 1'b1;
        end else begin
            case (sart_pkg::sart_xclk_t'(xsel))
                sart_pkg::SART_XCLK_DIV12: t = t12;
                sart_pkg::SART_XCLK_EXT8:  t = tx;
                sart_pkg::SART_XCLK_LFO8:  t = tl;
                default:                   t = 1'b0;        // reserved code never ticks
            endcase
        end
        return t;
    endfunction

    // synchroniser chains; stage 1 feeds stage 2 only
    logic ext_s1_ff, ext_s2_ff, ext_s3_ff;
    logic lfo_s1_ff, lfo_s2_ff, lfo_s3_ff;
    logic sus_s1_ff, sus_s2_ff;

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
            lfo_s1_ff <= 1'b0;
            lfo_s2_ff <= 1'b0;
            lfo_s3_ff <= 1'b0;
            sus_s1_ff <= 1'b0;
            sus_s2_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_clk_in;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
            lfo_s1_ff <= lfo_clk_in;
            lfo_s2_ff <= lfo_s1_ff;
            lfo_s3_ff <= lfo_s2_ff;
            sus_s1_ff <= suspend_in;
            sus_s2_ff <= sus_s1_ff;
        end
    end

    // prescalers
    logic [3:0] div12_ff, nxt_div12;
    logic [2:0] ext_div_ff, nxt_ext_div;
    logic [2:0] lfo_div_ff, nxt_lfo_div;
    logic       tick12, tick_ext, tick_lfo, ext_rise, lfo_rise, lfo_fall;

    // edges are taken between stages 2 and 3, never from stage 1
    always_comb begin
        ext_rise    = ext_s2_ff & ~ext_s3_ff;
        lfo_rise    = lfo_s2_ff & ~lfo_s3_ff;
        lfo_fall    = ~lfo_s2_ff & lfo_s3_ff;
        tick12      = (div12_ff == `SART_DIV12_LAST);
        nxt_div12   = tick12 ? 4'h0 : div12_ff + 4'h1;
        // in suspend the external and oscillator sources stop ticking; the divide by 12 keeps running
        tick_ext    = ext_rise & ~sus_s2_ff & (ext_div_ff == `SART_DIV8_LAST);
        tick_lfo    = lfo_rise & ~sus_s2_ff & (lfo_div_ff == `SART_DIV8_LAST);
        nxt_ext_div = (ext_rise & ~sus_s2_ff) ? ext_div_ff + 3'h1 : ext_div_ff;
        nxt_lfo_div = (lfo_rise & ~sus_s2_ff) ? lfo_div_ff + 3'h1 : lfo_div_ff;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div12_ff   <= 4'h0;
            ext_div_ff <= 3'h0;
            lfo_div_ff <= 3'h0;
        end else begin
            div12_ff   <= nxt_div12;
            ext_div_ff <= nxt_ext_div;
            lfo_div_ff <= nxt_lfo_div;
        end
    end

    // timer state and registers
    logic [7:0] lo_ff, nxt_lo, hi_ff, nxt_hi;
    logic [7:0] rll_ff, nxt_rll, rlh_ff, nxt_rlh;
    logic       tfh_ff, nxt_tfh, tfl_ff, nxt_tfl;
    logic       tflen_ff, nxt_tflen, capen_ff, nxt_capen;
    logic       split_ff, nxt_split, run_ff, nxt_run;
    logic [1:0] xclk_ff, nxt_xclk;
    logic       lsys_ff, nxt_lsys, hsys_ff, nxt_hsys, ien_ff, nxt_ien;
    logic       irq_ff, nxt_irq;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       tick_l, tick_h, wrap_l, wrap_h, cap_evt;
    logic       wr_ctrl, wr_lo, wr_hi, wr_rll, wr_rlh;

    // counting, capture, register writes and read data
    always_comb begin
        nxt_lo    = lo_ff;
        nxt_hi    = hi_ff;
        nxt_rll   = rll_ff;
        nxt_rlh   = rlh_ff;
        nxt_tfh   = tfh_ff;
        nxt_tfl   = tfl_ff;
        nxt_tflen = tflen_ff;
        nxt_capen = capen_ff;
        nxt_split = split_ff;
        nxt_run   = run_ff;
        nxt_xclk  = xclk_ff;
        nxt_lsys  = lsys_ff;
        nxt_hsys  = hsys_ff;
        nxt_ien   = ien_ff;
        nxt_rdata = 8'h00;
        wrap_l    = 1'b0;
        wrap_h    = 1'b0;
        wr_ctrl   = reg_wr & (reg_addr == `SART_ADDR_CTRL);
        wr_lo     = reg_wr & (reg_addr == `SART_ADDR_LOW);
        wr_hi     = reg_wr & (reg_addr == `SART_ADDR_HIGH);
        wr_rll    = reg_wr & (reg_addr == `SART_ADDR_RLD_LOW);
        wr_rlh    = reg_wr & (reg_addr == `SART_ADDR_RLD_HIGH);
        // both bytes share one alternate field
        tick_l    = sel_tick(lsys_ff, xclk_ff, tick12, tick_ext, tick_lfo);
        tick_h    = sel_tick(hsys_ff, xclk_ff, tick12, tick_ext, tick_lfo);
        cap_evt   = capen_ff & lfo_fall;
        if (split_ff) begin
            if (tick_l) begin
                wrap_l = (lo_ff == `SART_BYTE_MAX);
                nxt_lo = wrap_l ? rll_ff : lo_ff + 8'h01;
            end
            if (run_ff && tick_h) begin
                wrap_h = (hi_ff == `SART_BYTE_MAX);
                nxt_hi = wrap_h ? rlh_ff : hi_ff + 8'h01;
            end
        end else if (run_ff && tick_l) begin
            wrap_l = (lo_ff == `SART_BYTE_MAX);
            wrap_h = wrap_l & (hi_ff == `SART_BYTE_MAX);
            if (wrap_h) begin
                nxt_lo = rll_ff;
                nxt_hi = rlh_ff;
            end else begin
                {nxt_hi, nxt_lo} = {hi_ff, lo_ff} + 16'h0001;
            end
        end
        // capture beats a software reload write in the same cycle
        if (cap_evt) begin
            nxt_rll = lo_ff;
            nxt_rlh = hi_ff;
        end else begin
            if (wr_rll) begin
                nxt_rll = reg_wdata;
            end
            if (wr_rlh) begin
                nxt_rlh = reg_wdata;
            end
        end
        // software writes override the counting above
        if (wr_lo) begin
            nxt_lo = reg_wdata;
        end
        if (wr_hi) begin
            nxt_hi = reg_wdata;
        end
        if (wr_ctrl) begin
            nxt_tfh   = reg_wdata[`SART_CTRL_TFH];
            nxt_tfl   = reg_wdata[`SART_CTRL_TFL];
            nxt_tflen = reg_wdata[`SART_CTRL_TFLEN];
            nxt_capen = reg_wdata[`SART_CTRL_CAPEN];
            nxt_split = reg_wdata[`SART_CTRL_SPLIT];
            nxt_run   = reg_wdata[`SART_CTRL_RUN];
            nxt_xclk  = reg_wdata[`SART_CTRL_XCLK_HI:`SART_CTRL_XCLK_LO];
        end
        if (reg_wr && (reg_addr == `SART_ADDR_CLKCTL)) begin
            nxt_lsys = reg_wdata[`SART_CKC_LOW_SYS];
            nxt_hsys = reg_wdata[`SART_CKC_HIGH_SYS];
            nxt_ien  = reg_wdata[`SART_CKC_IRQ_EN];
        end
        // a wrap in the clearing cycle still sets its flag
        nxt_tfh = nxt_tfh | wrap_h;
        nxt_tfl = nxt_tfl | wrap_l;
        // level request while TFH stands or TFL stands with TFLEN set, pulse on capture
        nxt_irq = ien_ff & (tfh_ff | (tflen_ff & tfl_ff) | cap_evt);
        if (reg_rd) begin
            case (reg_addr)
                `SART_ADDR_CTRL:     nxt_rdata = {tfh_ff, tfl_ff, tflen_ff, capen_ff,
                                                  split_ff, run_ff, xclk_ff};
                `SART_ADDR_LOW:      nxt_rdata = lo_ff;
                `SART_ADDR_HIGH:     nxt_rdata = hi_ff;
                `SART_ADDR_RLD_LOW:  nxt_rdata = rll_ff;
                `SART_ADDR_RLD_HIGH: nxt_rdata = rlh_ff;
                `SART_ADDR_CLKCTL:   nxt_rdata = {5'h00, ien_ff, hsys_ff, lsys_ff};
                default:             nxt_rdata = 8'h00;     // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lo_ff    <= `SART_RST_BYTE;
            hi_ff    <= `SART_RST_BYTE;
            rll_ff   <= `SART_RST_BYTE;
            rlh_ff   <= `SART_RST_BYTE;
            tfh_ff   <= 1'b0;
            tfl_ff   <= 1'b0;
            tflen_ff <= 1'b0;
            capen_ff <= 1'b0;
            split_ff <= 1'b0;
            run_ff   <= 1'b0;
            xclk_ff  <= `SART_RST_XCLK;
            lsys_ff  <= 1'b0;
            hsys_ff  <= 1'b0;
            ien_ff   <= 1'b0;
            irq_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            lo_ff    <= nxt_lo;
            hi_ff    <= nxt_hi;
            rll_ff   <= nxt_rll;
            rlh_ff   <= nxt_rlh;
            tfh_ff   <= nxt_tfh;
            tfl_ff   <= nxt_tfl;
            tflen_ff <= nxt_tflen;
            capen_ff <= nxt_capen;
            split_ff <= nxt_split;
            run_ff   <= nxt_run;
            xclk_ff  <= nxt_xclk;
            lsys_ff  <= nxt_lsys;
            hsys_ff  <= nxt_hsys;
            ien_ff   <= nxt_ien;
            irq_ff   <= nxt_irq;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq_req   = irq_ff;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_SPLIT_LOW_RUNS: assert property (
        split_ff && !run_ff && tick_l && lo_ff != `SART_BYTE_MAX && !wr_lo
        |=> lo_ff == $past(lo_ff) + 8'h01)
        else $error("low byte did not count in split mode");

    AST_STOP_16: assert property (
        !split_ff && !run_ff && !wr_lo && !wr_hi |=> $stable({hi_ff, lo_ff}))
        else $error("16-bit counter moved while stopped");

    AST_SPLIT_HIGH_RELOAD: assert property (
        split_ff && run_ff && tick_h && hi_ff == `SART_BYTE_MAX && !wr_hi
        |=> hi_ff == $past(rlh_ff))
        else $error("high byte did not reload from its reload register");

    AST_TFL_SET: assert property (
        wrap_l |=> tfl_ff)
        else $error("low flag not set on low wrap");

    AST_TFH_16: assert property (
        !split_ff && run_ff && tick_l && {hi_ff, lo_ff} == 16'hffff
        |=> tfh_ff && ({hi_ff, lo_ff} == $past({rlh_ff, rll_ff}) || $past(wr_lo || wr_hi)))
        else $error("16-bit wrap missed flag or reload");

    AST_NO_HW_CLEAR: assert property (
        tfh_ff && tfl_ff && !wr_ctrl |=> tfh_ff && tfl_ff)
        else $error("hardware cleared an overflow flag");

    AST_IRQ_HIGH: assert property (
        ien_ff && tfh_ff |=> irq_req)
        else $error("high overflow gave no interrupt");

    AST_IRQ_LOW: assert property (
        ien_ff && tflen_ff && tfl_ff |=> irq_req)
        else $error("low overflow gave no interrupt");

    AST_IRQ_QUIET: assert property (
        !ien_ff || (!tfh_ff && !tfl_ff && !cap_evt) |=> !irq_req)
        else $error("interrupt without cause");

    AST_CAPTURE: assert property (
        cap_evt |=> {rlh_ff, rll_ff} == $past({hi_ff, lo_ff}))
        else $error("capture did not copy the count");

    AST_DIV12: assert property (
        tick12 |-> ##1 !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
        else $error("system clock divide by 12 off");

endmodule

`default_nettype wire

// ===== rtl/sart_map.svh
`ifndef SART_MAP_SVH
`define SART_MAP_SVH

// register addresses on the plain register port
`define SART_ADDR_CTRL     8'h91
`define SART_ADDR_LOW      8'h92
`define SART_ADDR_HIGH     8'h93
`define SART_ADDR_RLD_LOW  8'h94
`define SART_ADDR_RLD_HIGH 8'h95
`define SART_ADDR_CLKCTL   8'h96

// control register field positions
`define SART_CTRL_TFH      7
`define SART_CTRL_TFL      6
`define SART_CTRL_TFLEN    5
`define SART_CTRL_CAPEN    4
`define SART_CTRL_SPLIT    3
`define SART_CTRL_RUN      2
`define SART_CTRL_XCLK_HI  1
`define SART_CTRL_XCLK_LO  0

// clock control register field positions
`define SART_CKC_LOW_SYS   0
`define SART_CKC_HIGH_SYS  1
`define SART_CKC_IRQ_EN    2

// reset values
`define SART_RST_BYTE      8'h00
`define SART_RST_XCLK      2'h0

// divider counts
`define SART_DIV12_LAST    4'hb
`define SART_DIV8_LAST     3'h7
`define SART_BYTE_MAX      8'hff

`endif

// ===== rtl/sart_pkg.sv
package sart_pkg;

    // alternate clock source codes
    typedef enum logic [1:0] {
        SART_XCLK_DIV12 = 2'h0,
        SART_XCLK_EXT8  = 2'h1,
        SART_XCLK_RSVD  = 2'h2,
        SART_XCLK_LFO8  = 2'h3
    } sart_xclk_t;

endpackage

// ===== tb/sart_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none

module sart_timer_tb;
    // stimulus and observed signals
    logic       clk        = 1'b0;
    logic       reset      = 1'b1;
    logic [7:0] reg_addr   = 8'h00;
    logic [7:0] reg_wdata  = 8'h00;
    logic       reg_wr     = 1'b0;
    logic       reg_rd     = 1'b0;
    logic [7:0] reg_rdata;
    logic       ext_clk_in = 1'b0;
    logic       lfo_clk_in = 1'b0;
    logic       suspend_in = 1'b0;
    logic       irq_req;
    int         bad_count       = 0;
    int         samples_checked = 0;

    // 100 ns system clock
    always #50 clk = ~clk;

    sart_timer uut (
        .clk        (clk),
        .reset      (reset),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .ext_clk_in (ext_clk_in),
        .lfo_clk_in (lfo_clk_in),
        .suspend_in (suspend_in),
        .irq_req    (irq_req)
    );

    // single compare point, four-state equality
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle write strobe; an idle edge follows so back-to-back calls
    // never drive the strobe twice in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    // read, data sampled only in the cycle after the strobe; mask hides tick jitter in the low count bits
    task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata & m, e);
        @(posedge clk);
    endtask

    // irq level is registered one cycle after its cause
    task automatic irqc(input logic e);
        repeat (2) @(posedge clk);
        #1 check({7'h00, irq_req}, {7'h00, e});
        @(posedge clk);
    endtask

    // slow pin pulses, four cycles each so the synchronizer sees every edge
    task automatic pins(input logic sel, input int n);
        repeat (n) begin
            ext_clk_in <= ~sel;
            lfo_clk_in <= sel;
            repeat (2) @(posedge clk);
            ext_clk_in <= 1'b0;
            lfo_clk_in <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // main sequence; alt code 10 plus select 0 is used to freeze counters before reading
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int a = 8'h90; a <= 8'h97; a++) rdc(a[7:0], 8'hff, 8'h00);
        wr(8'h91, 8'h3e);
        rdc(8'h91, 8'hff, 8'h3e);
        wr(8'h94, 8'ha5);
        rdc(8'h94, 8'hff, 8'ha5);
        $display("test reset and access done");
        // split mode: low free-runs on the system clock, high stopped
        wr(8'h91, 8'h0a);
        wr(8'h92, 8'hf0);
        wr(8'h93, 8'h33);
        wr(8'h94, 8'h80);
        wr(8'h96, 8'h01);
        repeat (20) @(posedge clk);
        wr(8'h96, 8'h04);
        rdc(8'h91, 8'hff, 8'h4a);
        rdc(8'h93, 8'hff, 8'h33);
        rdc(8'h92, 8'hf0, 8'h80);
        irqc(1'b0);
        wr(8'h91, 8'h6a);
        irqc(1'b1);
        wr(8'h91, 8'h2a);
        irqc(1'b0);
        rdc(8'h91, 8'hff, 8'h2a);
        $display("test split done");
        // 16-bit mode: held while stopped, then wraps 0xffff into the reload pair
        wr(8'h91, 8'h02);
        wr(8'h92, 8'hf0);
        wr(8'h93, 8'hff);
        wr(8'h94, 8'h11);
        wr(8'h95, 8'h22);
        wr(8'h96, 8'h05);
        repeat (20) @(posedge clk);
        rdc(8'h92, 8'hff, 8'hf0);
        wr(8'h91, 8'h06);
        repeat (20) @(posedge clk);
        wr(8'h96, 8'h04);
        rdc(8'h91, 8'hff, 8'hc6);
        rdc(8'h93, 8'hff, 8'h22);
        rdc(8'h92, 8'hf0, 8'h10);
        irqc(1'b1);
        $display("test 16-bit done");
        // divide by 12 shared by both bytes
        wr(8'h91, 8'h0c);
        wr(8'h92, 8'h00);
        wr(8'h93, 8'h00);
        repeat (108) @(posedge clk);
        wr(8'h91, 8'h0e);
        rdc(8'h92, 8'hfc, 8'h08);
        rdc(8'h93, 8'hfc, 8'h08);
        // external clock divided by 8, and frozen while suspended
        wr(8'h91, 8'h09);
        wr(8'h92, 8'h00);
        pins(1'b0, 16);
        rdc(8'h92, 8'hff, 8'h02);
        suspend_in <= 1'b1;
        repeat (4) @(posedge clk);
        pins(1'b0, 16);
        suspend_in <= 1'b0;
        repeat (4) @(posedge clk);
        rdc(8'h92, 8'hff, 8'h02);
        $display("test clock sources done");
        // oscillator source with capture of the count into the reloads
        wr(8'h93, 8'h77);
        wr(8'h91, 8'h1b);
        wr(8'h92, 8'h00);
        pins(1'b1, 8);
        rdc(8'h92, 8'hff, 8'h01);
        rdc(8'h95, 8'hff, 8'h77);
        rdc(8'h94, 8'hfe, 8'h00);
        $display("test capture done");
        // split high byte on the system clock for two ticks wraps into its own reload
        wr(8'h91, 8'h0e);
        wr(8'h95, 8'h40);
        wr(8'h93, 8'hfe);
        wr(8'h96, 8'h06);
        wr(8'h96, 8'h04);
        rdc(8'h93, 8'hff, 8'h40);
        rdc(8'h92, 8'hff, 8'h01);
        rdc(8'h91, 8'hff, 8'h8e);
        irqc(1'b1);
        $display("test high reload done");
        final_report();
    end

    // watchdog: the sequence needs well under 1500 cycles
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        final_report();
    end
endmodule

`default_nettype wire
